/* File: rtl/dbf_defs.svh */
// Constants for the byte-wide input elastic buffer
`ifndef DBF_DEFS_SVH
`define DBF_DEFS_SVH
`define DBF_DEPTH 8
`define DBF_WR_PTR_RESET 3'h0
`define DBF_RD_PTR_DEFAULT 3'h4
`define DBF_SYNC_SEL_FRAME 1'b0
`define DBF_SYNC_SEL_OUTPUT_SYNC_STROBE 1'b1
`define DBF_ALARM_COLLISION 0
`define DBF_ALARM_NEAR_ONE 1
`define DBF_ALARM_NEAR_TWO 2
`define DBF_I_HI_LSB 24
`define DBF_I_LO_LSB 16
`define DBF_Q_HI_LSB 8
`endif

/* File: rtl/dbf_input_fifo.sv */
// Byte-wide double-data-rate input path with 8-deep elastic sample buffer
//
// Overview of operation
// - Eight-bit input bus carries two 16-bit samples as bytes, bit 0 is LSB
// - Data bytes are captured on both edges of the byte clock
// - Marker is sampled on byte-clock rising edges only
// - Buffer holds two 16-bit channels, eight sample entries deep
// - Four bytes over two byte-clock periods form one 32-bit entry at write pointer
// - Read side ticks at conversion clock over interpolation, one entry per tick
// - Each write advances the write pointer; each read advances the read pointer, or loads the offset if a marker read reset is pending
// - Pointer reset puts write pointer at 0, read pointer at 4 by default
// - A three-bit offset sets the read pointer reset position
// - Rising marker edge resets pointers, write pointer always to 0
// - Sync select picks marker or output sync strobe as read reset source
// - Marker used for read reset is recaptured in the read timing first
// - Output sync strobe is sampled by conversion clock, resets read pointer alone
// - With both reset enables low, marker and strobe edges are ignored
// - Three alarms: within two, within one, and pointers equal
// - Alarms follow pointers continuously, on status bits and an alarm pin
`timescale 1ns/1ns
`include "dbf_defs.svh"

module dbf_input_fifo
    import dbf_pkg::*;
#(
    parameter int DEPTH = `DBF_DEPTH
)
(
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    input wire logic CLK_EN_IN,
    input wire logic BYTE_CLK_IN,
    input wire logic [7:0] DATA_IN,
    input wire logic FRAME_IN,
    input wire logic CONV_CLK_IN,
    input wire logic OUT_SYNC_IN,
    input wire logic [3:0] INTERP_IN,
    input wire logic [2:0] PTR_OFFSET_IN,
    input wire logic SYNC_SEL_IN,
    input wire logic PTR_RESET_EN_IN,
    input wire logic READ_SYNC_EN_IN,
    output logic [31:0] SAMPLE_OUT,
    output logic SAMPLE_VALID_OUT,
    output logic [2:0] WR_PTR_OUT,
    output logic [2:0] RD_PTR_OUT,
    output logic [2:0] ALARM_STATUS_OUT,
    output logic ALARM_PIN_OUT
);
    localparam int PW = $clog2(DEPTH);

    if (DEPTH != 8)
    begin : g_bad_depth
        $error("Pointer ports are three bits wide, depth must be 8");
    end

    function automatic logic [PW-1:0] ptr_gap(input logic [PW-1:0] a, input logic [PW-1:0] b);
        ptr_gap = a - b;
    endfunction

    logic [31:0] mem [DEPTH];
    logic [31:0] asm_word;
    dbf_phase_t phase;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic byte_clk_q;
    logic frame_q;
    logic conv_clk_q;
    logic output_sync_strobe_q;
    logic [3:0] div_cnt;
    logic rd_sync_pend;

    logic byte_rise;
    logic byte_edge;
    logic frame_edge;
    logic conv_rise;
    logic output_sync_strobe_edge;
    logic [3:0] interp_m1;
    logic rd_tick;
    logic write_now;
    logic wr_reset;
    logic frame_rd_req;
    logic output_sync_strobe_rd_req;
    logic [PW-1:0] gap;

    // Both inputs are synchronous to the reference clock, so edges are found by compare
    assign byte_rise = BYTE_CLK_IN & ~byte_clk_q;
    assign byte_edge = BYTE_CLK_IN ^ byte_clk_q;
    assign frame_edge = byte_rise & FRAME_IN & ~frame_q;
    assign conv_rise = CONV_CLK_IN & ~conv_clk_q;
    assign output_sync_strobe_edge = conv_rise & OUT_SYNC_IN & ~output_sync_strobe_q;
    assign interp_m1 = (INTERP_IN == 4'h0) ? 4'h0 : INTERP_IN - 4'h1;
    assign rd_tick = conv_rise & (div_cnt >= interp_m1);
    assign write_now = byte_edge & ~frame_edge & (phase == DBF_Q_LO);
    assign wr_reset = frame_edge & PTR_RESET_EN_IN;
    assign frame_rd_req = frame_edge & READ_SYNC_EN_IN & (SYNC_SEL_IN == `DBF_SYNC_SEL_FRAME);
    assign output_sync_strobe_rd_req = output_sync_strobe_edge & READ_SYNC_EN_IN & (SYNC_SEL_IN == `DBF_SYNC_SEL_OUTPUT_SYNC_STROBE);
    assign gap = ptr_gap(wr_ptr, rd_ptr);

    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
        begin
            byte_clk_q <= 1'b0;
            frame_q <= 1'b0;
            conv_clk_q <= 1'b0;
            output_sync_strobe_q <= 1'b0;
        end
        else if (CLK_EN_IN)
        begin
            byte_clk_q <= BYTE_CLK_IN;
            conv_clk_q <= CONV_CLK_IN;
            if (byte_rise)
            begin
                frame_q <= FRAME_IN;
            end
            if (conv_rise)
            begin
                output_sync_strobe_q <= OUT_SYNC_IN;
            end
        end
    end

    // Byte order per sample: I high, I low, Q high, Q low; the marker edge marks I high
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
        begin
            phase <= DBF_I_HI;
            asm_word <= 32'h0000_0000;
        end
        else if (CLK_EN_IN && byte_edge)
        begin
            if (frame_edge)
            begin
                asm_word[`DBF_I_HI_LSB +: 8] <= DATA_IN;
                phase <= DBF_I_LO;
            end
            else
            begin
                unique case (phase)
                    DBF_I_HI:
                    begin
                        asm_word[`DBF_I_HI_LSB +: 8] <= DATA_IN;
                        phase <= DBF_I_LO;
                    end
                    DBF_I_LO:
                    begin
                        asm_word[`DBF_I_LO_LSB +: 8] <= DATA_IN;
                        phase <= DBF_Q_HI;
                    end
                    DBF_Q_HI:
                    begin
                        asm_word[`DBF_Q_HI_LSB +: 8] <= DATA_IN;
                        phase <= DBF_Q_LO;
                    end
                    DBF_Q_LO:
                    begin
                        phase <= DBF_I_HI;
                    end
                endcase
            end
        end
    end

    // Storage has no reset; entries are only meaningful once written
    always_ff @(posedge REF_CLK_IN)
    begin
        if (CLK_EN_IN && write_now)
        begin
            mem[wr_ptr] <= {asm_word[31:8], DATA_IN};
        end
    end

    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
        begin
            wr_ptr <= `DBF_WR_PTR_RESET;
        end
        else if (CLK_EN_IN)
        begin
            if (wr_reset)
            begin
                wr_ptr <= `DBF_WR_PTR_RESET;
            end
            else if (write_now)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
        end
    end

    // Marker-driven read reset waits for the next read tick, hence the phase uncertainty
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
        begin
            rd_sync_pend <= 1'b0;
        end
        else if (CLK_EN_IN)
        begin
            if (frame_rd_req)
            begin
                rd_sync_pend <= 1'b1;
            end
            else if (rd_tick || output_sync_strobe_rd_req)
            begin
                rd_sync_pend <= 1'b0;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
        begin
            div_cnt <= 4'h0;
        end
        else if (CLK_EN_IN)
        begin
            if (output_sync_strobe_rd_req || rd_tick)
            begin
                div_cnt <= 4'h0;
            end
            else if (conv_rise)
            begin
                div_cnt <= div_cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
        begin
            rd_ptr <= PTR_OFFSET_IN;
            SAMPLE_OUT <= 32'h0000_0000;
            SAMPLE_VALID_OUT <= 1'b0;
        end
        else if (CLK_EN_IN)
        begin
            SAMPLE_VALID_OUT <= rd_tick & ~output_sync_strobe_rd_req;
            if (output_sync_strobe_rd_req)
            begin
                rd_ptr <= PTR_OFFSET_IN;
            end
            else if (rd_tick)
            begin
                SAMPLE_OUT <= mem[rd_ptr];
                rd_ptr <= rd_sync_pend ? PTR_OFFSET_IN : rd_ptr + 1'b1;
            end
        end
        else
        begin
            SAMPLE_VALID_OUT <= 1'b0;
        end
    end

    // Alarms track the pointers every cycle; registered only to keep outputs glitch free
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
        begin
            ALARM_STATUS_OUT <= 3'h0;
            ALARM_PIN_OUT <= 1'b0;
        end
        else if (CLK_EN_IN)
        begin
            ALARM_STATUS_OUT[`DBF_ALARM_COLLISION] <= (gap == 0);
            ALARM_STATUS_OUT[`DBF_ALARM_NEAR_ONE] <= (gap <= 1) || (gap >= PW'(DEPTH - 1));
            ALARM_STATUS_OUT[`DBF_ALARM_NEAR_TWO] <= (gap <= 2) || (gap >= PW'(DEPTH - 2));
            ALARM_PIN_OUT <= (gap <= 2) || (gap >= PW'(DEPTH - 2));
        end
    end

    assign WR_PTR_OUT = wr_ptr;
    assign RD_PTR_OUT = rd_ptr;

    property p_wr_advance;
        @(posedge REF_CLK_IN) disable iff (RST_IN)
        CLK_EN_IN && write_now && !wr_reset |=> wr_ptr == PW'($past(wr_ptr) + 1'b1);
    endproperty
    a_wr_advance: assert property (p_wr_advance) else $error("write pointer did not advance");

    property p_wr_reset;
        @(posedge REF_CLK_IN) disable iff (RST_IN)
        CLK_EN_IN && frame_edge && PTR_RESET_EN_IN |=> wr_ptr == 3'h0;
    endproperty
    a_wr_reset: assert property (p_wr_reset) else $error("marker edge did not clear write pointer");

    property p_output_sync_strobe_reset;
        @(posedge REF_CLK_IN) disable iff (RST_IN)
        CLK_EN_IN && output_sync_strobe_edge && READ_SYNC_EN_IN && SYNC_SEL_IN |=> rd_ptr == $past(PTR_OFFSET_IN);
    endproperty
    a_output_sync_strobe_reset: assert property (p_output_sync_strobe_reset) else $error("strobe did not load read offset");

    property p_frame_rd_reset;
        @(posedge REF_CLK_IN) disable iff (RST_IN)
        CLK_EN_IN && rd_sync_pend && rd_tick && !output_sync_strobe_rd_req |=> rd_ptr == $past(PTR_OFFSET_IN);
    endproperty
    a_frame_rd_reset: assert property (p_frame_rd_reset) else $error("recaptured marker missed");

    property p_ignore;
        @(posedge REF_CLK_IN) disable iff (RST_IN)
        CLK_EN_IN && !PTR_RESET_EN_IN && !READ_SYNC_EN_IN && frame_edge |=> wr_ptr == $past(wr_ptr) && !rd_sync_pend;
    endproperty
    a_ignore: assert property (p_ignore) else $error("disabled reset still acted");

    property p_frame_rise_only;
        @(posedge REF_CLK_IN) disable iff (RST_IN)
        !byte_rise |=> $stable(frame_q);
    endproperty
    a_frame_rise_only: assert property (p_frame_rise_only) else $error("marker sampled off rising edge");

    property p_collision;
        @(posedge REF_CLK_IN) disable iff (RST_IN)
        CLK_EN_IN && wr_ptr == rd_ptr |=> ALARM_STATUS_OUT == 3'h7 && ALARM_PIN_OUT;
    endproperty
    a_collision: assert property (p_collision) else $error("collision alarms missing");

    property p_alarm_pin;
        @(posedge REF_CLK_IN) disable iff (RST_IN)
        ALARM_PIN_OUT == ALARM_STATUS_OUT[`DBF_ALARM_NEAR_TWO];
    endproperty
    a_alarm_pin: assert property (p_alarm_pin) else $error("alarm pin disagrees with status");

    property p_read_tick;
        @(posedge REF_CLK_IN) disable iff (RST_IN)
        CLK_EN_IN && rd_tick && !output_sync_strobe_rd_req |=> SAMPLE_VALID_OUT && SAMPLE_OUT == $past(mem[rd_ptr]);
    endproperty
    a_read_tick: assert property (p_read_tick) else $error("read tick gave no sample");
endmodule

/* File: rtl/dbf_pkg.sv */
// Types for the byte-wide input elastic buffer
package dbf_pkg;
    typedef enum logic [1:0] {
        DBF_I_HI,
        DBF_I_LO,
        DBF_Q_HI,
        DBF_Q_LO
    } dbf_phase_t;
endpackage

/* File: sim/dbf_source.sv */
// Source model driving data bytes and the block-start marker
`timescale 1ns/1ns
module dbf_source (
    input wire logic clk_in,
    output logic byte_clk_out,
    output logic [7:0] data_out,
    output logic frame_out
);
    initial
    begin
        byte_clk_out = 1'b0;
        data_out = 8'h00;
        frame_out = 1'b0;
    end
    // Byte clock stands still between samples; one byte per edge, I high first
    task automatic send(input logic [31:0] s, input logic f);
        for (int b = 0; b < 4; b++)
        begin
            @(negedge clk_in);
            byte_clk_out = ~byte_clk_out;
            data_out = s[31-8*b -: 8];
            // Marker rides the rising edge and stays a full half period
            frame_out = f && (b == 0);
        end
        @(negedge clk_in);
        // Released bus must not keep showing the last byte
        data_out = ~data_out;
    endtask
endmodule

/* File: sim/test_dbf_input_fifo.sv */
// Self-checking bench for the byte-wide input elastic buffer
`timescale 1ns/1ns
module test_dbf_input_fifo;
    import dbf_pkg::*;
    logic clk, rst, conv, osync, sel, wen, ren, bclk, frm, vld, pin, got, en;
    logic [7:0] data;
    logic [3:0] interp;
    logic [2:0] off, wp, rp, al;
    logic [31:0] smp;
    logic [31:0] mem [8];
    int fails = 0, check_count = 0, wr, rd, lf = 32'h8909;
    bit pend, cnt_ok;

    dbf_source i_src (.clk_in(clk), .byte_clk_out(bclk), .data_out(data), .frame_out(frm));
    dbf_input_fifo i_dut (.REF_CLK_IN(clk), .RST_IN(rst), .CLK_EN_IN(en), .BYTE_CLK_IN(bclk),
        .DATA_IN(data), .FRAME_IN(frm), .CONV_CLK_IN(conv), .OUT_SYNC_IN(osync), .INTERP_IN(interp),
        .PTR_OFFSET_IN(off), .SYNC_SEL_IN(sel), .PTR_RESET_EN_IN(wen), .READ_SYNC_EN_IN(ren),
        .SAMPLE_OUT(smp), .SAMPLE_VALID_OUT(vld), .WR_PTR_OUT(wp), .RD_PTR_OUT(rp),
        .ALARM_STATUS_OUT(al), .ALARM_PIN_OUT(pin));

    function automatic int rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction

    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            fails++;
            $display("wrong value %s expected %0h seen %0h", n, e, g);
        end
    endtask

    task automatic chk_state();
        int g;
        g = (wr - rd) & 7;
        chk("wr_ptr", wr, wp);
        chk("rd_ptr", rd, rp);
        chk("alarms", {g <= 2 || g >= 6, g <= 1 || g == 7, g == 0}, al);
        chk("alarm_pin", g <= 2 || g >= 6, pin);
    endtask

    task automatic put(logic f);
        logic [31:0] s;
        s = rnd();
        i_src.send(s, f);
        if (f && wen)
            wr = 0;
        mem[wr] = s;
        wr = (wr + 1) & 7;
        if (f && ren && !sel)
            pend = 1;
        @(negedge clk);
        chk_state();
    endtask

    // Valid may land one cycle after the rise, so three cycles are watched
    task automatic tick();
        conv = 1;
        @(negedge clk);
        conv = 0;
        got |= vld === 1'b1;
        repeat (2)
        begin
            @(negedge clk);
            got |= vld === 1'b1;
        end
    endtask

    task automatic get();
        int n;
        n = 0;
        got = 0;
        while (!got && n < 12)
        begin
            tick();
            n++;
        end
        chk("valid", 1, got);
        chk("read_count", cnt_ok ? interp : n, n);
        chk("sample", mem[rd], smp);
        rd = pend ? off : (rd + 1) & 7;
        pend = 0;
        cnt_ok = 1;
        chk_state();
    endtask

    task automatic strobe();
        osync = 1;
        got = 0;
        tick();
        osync = 0;
        // Divider restarts on an accepted strobe or on a read; otherwise the count is partial
        cnt_ok = (ren && sel) || got;
        if (ren && sel)
        begin
            chk("dropped_read", 0, got);
            rd = off;
        end
        else if (got)
        begin
            chk("sample", mem[rd], smp);
            rd = (rd + 1) & 7;
        end
        chk_state();
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        clk = 0;
        forever #25 clk = ~clk;
    end

    // The whole run needs well under a thousand cycles
    initial
    begin
        #(50 * 5000);
        fails++;
        wrap_up();
    end

    initial
    begin
        {rst, conv, osync, sel, wen, ren, off, interp} = {1'b1, 5'h03, 3'h4, 4'h1};
        {wr, rd, pend, cnt_ok, got} = {32'h0, 32'h4, 3'h0};
        en = 1;
        repeat (5) @(negedge clk);
        rst = 0;
        @(negedge clk);
        chk_state();
        $display("test reset done");
        interp = 4'((rnd() & 3) + 1);
        for (int k = 0; k < 8; k++)
            put(k == 0);
        $display("test write done");
        for (int k = 0; k < 6; k++)
            get();
        $display("test read done");
        sel = 1;
        ren = 1;
        off = 3'(rnd());
        strobe();
        repeat (7) get();
        // Next strobe lands a whole eight reads after the first one
        repeat (interp - 1) tick();
        ren = 0;
        strobe();
        wen = 0;
        put(1);
        // Marker recurs only after eight whole samples
        for (int k = 0; k < 7; k++)
            put(0);
        $display("test strobe and disable done");
        wen = 1;
        ren = 1;
        sel = 0;
        put(1);
        get();
        // Enable low must hide conversion edges and hold every pointer
        en = 0;
        got = 0;
        repeat (4) tick();
        chk("frozen_valid", 0, got);
        chk_state();
        en = 1;
        get();
        $display("test marker read reset done");
        wrap_up();
    end
endmodule
